// ===== shared/msm_pkg.sv
// Package: memory strobe mapper constants, enums and carrier structs
package msm_pkg;

	// ----------------------------------------------------------------
	// Pin indices of the shared control bus
	// ----------------------------------------------------------------
	localparam int PIN_COUNT     = 10;  // Shared control pins
	localparam int BANK_COUNT    = 6;   // Banks / chip selects 0..5
	localparam int DRAM_CAS_LAST = 4;   // Per-bank column strobes on pins 0..4
	localparam int PIN_P4        = 4;   // Even refresh pin (small PSRAM)
	localparam int PIN_P5        = 5;
	localparam int PIN_P6        = 6;
	localparam int PIN_P7        = 7;
	localparam int PIN_P8        = 8;
	localparam int PIN_P9        = 9;

	// ----------------------------------------------------------------
	// Address constants
	// ----------------------------------------------------------------
	localparam logic [23:0] BOOT_LO     = 24'h0F_0000; // Boot window start
	localparam logic [23:0] BOOT_HI     = 24'h0F_FFFF; // Boot window end
	localparam logic [7:0]  UPPER_ZERO  = 8'h00;       // Forced upper byte
	localparam int          UPPER_MSB   = 23;
	localparam int          UPPER_LSB   = 16;
	localparam logic [9:0]  PINS_IDLE   = 10'h3FF;     // All strobes high

	// ----------------------------------------------------------------
	// Timing constants (access times in ns, strobe phases in clock cycles)
	// ----------------------------------------------------------------
	localparam int CLOCK_MHZ     = 100;
	localparam int DRAM_NS       = 60;   // DRAM access time
	localparam int SRAM_NS       = 60;   // SRAM access time
	localparam int PSRAM_NS      = 80;   // PSRAM access time
	localparam int DRAM_CYC      = (DRAM_NS * CLOCK_MHZ + 999) / 1000;
	localparam int SRAM_CYC      = (SRAM_NS * CLOCK_MHZ + 999) / 1000;
	localparam int PSRAM_CYC     = (PSRAM_NS * CLOCK_MHZ + 999) / 1000;
	localparam int RAS_CAS_CYC   = 2;    // Row to column step
	localparam int CNT_W         = 8;
	localparam int REFRESH_W     = 8;    // Refresh timer width

	// ----------------------------------------------------------------
	// Memory types and targets
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MSM_DRAM_X8,
		MSM_DRAM_X16,
		MSM_SRAM,
		MSM_PSRAM_SMALL,
		MSM_PSRAM_LARGE,
		MSM_FLASH_X8,
		MSM_FLASH_X16
	} msm_mem_type_t;

	typedef enum logic [1:0] {
		MSM_TGT_RAM,
		MSM_TGT_FIRST_ROM,
		MSM_TGT_SECOND_ROM,
		MSM_TGT_NONE
	} msm_target_t;

	// Access request from the processor side
	typedef struct packed {
		logic        write;     // 1 = write
		logic        low_byte;  // Even byte lane used
		logic        high_byte; // Odd byte lane used
		logic [2:0]  bank;      // Bank 0..5
		logic [23:0] addr;      // Physical address
		msm_target_t target;    // Mapping-register target
		logic        mapped;    // Went through a mapping register
	} msm_req_t;

	// Static configuration
	typedef struct packed {
		msm_mem_type_t ram_type;       // Type of every RAM bank
		logic          boot_shadowed;  // Boot window shadowed by RAM
		logic          second_rom_x8;  // Second ROM width bit
		logic          flash_oe_on_rd; // Expansion read drives flash OE
		logic          dram_self_ref;  // Self-refreshing DRAM fitted
		logic [7:0]    refresh_div;    // Refresh period in ticks
	} msm_cfg_t;

endpackage : msm_pkg

// ===== rtl/msm_refresh_timer.sv
// Independent 8-bit refresh request timer
`timescale 1ns/100ps
`default_nettype none
module msm_refresh_timer #(
	parameter int WIDTH = msm_pkg::REFRESH_W
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             run,       // Timer enabled
	input  wire logic [WIDTH-1:0] period,    // Reload value
	input  wire logic             ack,       // Refresh cycle taken
	output logic                  request    // Pending refresh
);

	// ----------------------------------------------------------------
	// Counter and sticky request
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] count;       // Down counter
	logic [WIDTH-1:0] next_count;
	logic             next_request;

	// Next-state: reload on expiry; a new expiry beats an ack
	always_comb begin
		next_count   = count;
		next_request = request;
		if (ack) begin
			next_request = 1'b0;
		end
		if (!run) begin
			next_count   = period;
			next_request = 1'b0;
		end else if (count == '0) begin
			next_count   = period;
			next_request = 1'b1;
		end else begin
			next_count = count - 1'b1;
		end
	end

	// Registers only
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count   <= '0;
			request <= 1'b0;
		end else begin
			count   <= next_count;
			request <= next_request;
		end
	end

endmodule : msm_refresh_timer
`default_nettype wire

// ===== rtl/msm_strobe_mapper.sv
// Memory strobe mapper: RAM control pins, ROM selects, refresh sequencing
`timescale 1ns/100ps
`default_nettype none
module msm_strobe_mapper (
	input  wire logic               clock,
	input  wire logic               resetn,
	input  wire msm_pkg::msm_cfg_t  cfg,           // Static configuration
	input  wire logic               req_valid,     // Processor access request
	input  wire msm_pkg::msm_req_t  req,           // Request fields
	input  wire logic               disp_valid,    // Display refresh burst request
	input  wire logic [3:0]         disp_len,      // Words in burst, minus one
	input  wire logic               suspend,       // Suspend state, async level
	input  wire logic               boot_rom_width_strap, // Pin: low 16-bit, high 8-bit
	input  wire logic               exp_read,      // Expansion memory read phase
	output logic                    busy,          // Cycle in progress
	output logic                    done,          // One-cycle end of access
	output logic [9:0]              mem_ctl_pins_n,       // Shared control pins
	output logic                    boot_rom_select_n,    // First ROM enable
	output logic                    second_rom_select_n,  // Second ROM enable
	output logic                    expansion_mem_read_strobe_n, // Flash OE
	output logic [7:0]              upper_addr,    // Address bits 23..16
	output logic                    rom_x8,        // Width of ROM now selected
	output logic                    boot_rom_x8    // Latched strap
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] strap_sync;     // Strap pin, two flops
	logic [1:0] suspend_sync;   // Suspend level, two flops
	logic       suspend_s;      // Synchronised suspend

	// Only the second stage is read
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap_sync   <= 2'b00;
			suspend_sync <= 2'b00;
		end else begin
			strap_sync   <= {strap_sync[0], boot_rom_width_strap};
			suspend_sync <= {suspend_sync[0], suspend};
		end
	end
	assign suspend_s = suspend_sync[1];

	// ----------------------------------------------------------------
	// Boot width strap capture after reset release
	// ----------------------------------------------------------------
	logic       strap_taken;    // Strap has been caught
	logic       next_strap_taken;
	logic       next_boot_rom_x8;
	logic [1:0] strap_wait;     // Lets the synchroniser fill
	logic [1:0] next_strap_wait;

	// Catch once the sync chain holds a real sample
	always_comb begin
		next_strap_wait  = strap_wait;
		next_strap_taken = strap_taken;
		next_boot_rom_x8 = boot_rom_x8;
		if (!strap_taken) begin
			if (strap_wait == 2'd2) begin
				next_strap_taken = 1'b1;
				next_boot_rom_x8 = strap_sync[1];
			end else begin
				next_strap_wait = strap_wait + 2'd1;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap_wait  <= 2'd0;
			strap_taken <= 1'b0;
			boot_rom_x8 <= 1'b0;
		end else begin
			strap_wait  <= next_strap_wait;
			strap_taken <= next_strap_taken;
			boot_rom_x8 <= next_boot_rom_x8;
		end
	end

	// ----------------------------------------------------------------
	// Refresh timer
	// ----------------------------------------------------------------
	logic ref_req;   // Pending refresh
	logic ref_ack;   // Refresh cycle started
	logic ref_run;   // Timer allowed

	// PSRAM self-refreshes in suspend; so does self-refreshing DRAM
	assign ref_run = !(suspend_s && (cfg.ram_type == msm_pkg::MSM_PSRAM_SMALL
		|| cfg.ram_type == msm_pkg::MSM_PSRAM_LARGE || cfg.dram_self_ref));

	msm_refresh_timer #(
		.WIDTH (msm_pkg::REFRESH_W)
	) u_refresh (
		.clock   (clock),
		.resetn  (resetn),
		.run     (ref_run),
		.period  (cfg.refresh_div),
		.ack     (ref_ack),
		.request (ref_req)
	);

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MSM_IDLE,
		MSM_ROW,       // Row / chip select phase
		MSM_COL,       // Column / strobe phase
		MSM_PAGE,      // Page-mode column steps
		MSM_REF_COL,   // Refresh: column strobes first
		MSM_REF_ROW,   // Refresh: then row strobes
		MSM_ROM        // ROM access
	} msm_state_t;

	msm_state_t                      state, next_state;
	msm_pkg::msm_req_t               cur, next_cur;        // Latched request
	logic [msm_pkg::CNT_W-1:0]       count, next_count;    // Phase timer
	logic [3:0]                      beats, next_beats;    // Page beats left
	logic                            is_disp, next_is_disp;
	logic                            in_boot;              // Boot window hit
	logic                            is_dram;              // DRAM fitted
	logic                            is_psram;             // PSRAM fitted
	logic [msm_pkg::CNT_W-1:0]       acc_cyc;              // Access phase length

	assign in_boot = (req.addr >= msm_pkg::BOOT_LO) && (req.addr <= msm_pkg::BOOT_HI);
	assign is_dram = (cfg.ram_type == msm_pkg::MSM_DRAM_X8)
		|| (cfg.ram_type == msm_pkg::MSM_DRAM_X16);
	assign is_psram = (cfg.ram_type == msm_pkg::MSM_PSRAM_SMALL)
		|| (cfg.ram_type == msm_pkg::MSM_PSRAM_LARGE);

	// Access time per type, in whole clocks
	always_comb begin
		if (is_dram) begin
			acc_cyc = msm_pkg::CNT_W'(msm_pkg::DRAM_CYC);
		end else if (is_psram) begin
			acc_cyc = msm_pkg::CNT_W'(msm_pkg::PSRAM_CYC);
		end else begin
			acc_cyc = msm_pkg::CNT_W'(msm_pkg::SRAM_CYC);
		end
	end

	// Next-state: refresh wins over a new access; requests held by caller
	always_comb begin
		next_state   = state;
		next_cur     = cur;
		next_count   = count;
		next_beats   = beats;
		next_is_disp = is_disp;
		ref_ack      = 1'b0;
		done         = 1'b0;
		case (state)
			MSM_IDLE: begin
				if (ref_req && (is_dram || is_psram) && ref_run) begin
					ref_ack    = 1'b1;
					next_state = MSM_REF_COL;
					next_count = msm_pkg::CNT_W'(msm_pkg::RAS_CAS_CYC);
				end else if (disp_valid && is_dram) begin
					next_is_disp = 1'b1;
					next_beats   = disp_len;
					next_cur     = req;
					next_cur.write     = 1'b0;
					next_cur.low_byte  = 1'b1;
					next_cur.high_byte = 1'b1;
					next_state   = MSM_ROW;
					next_count   = msm_pkg::CNT_W'(msm_pkg::RAS_CAS_CYC);
				end else if (req_valid) begin
					next_is_disp = 1'b0;
					next_cur     = req;
					next_count   = acc_cyc;
					if (in_boot && !cfg.boot_shadowed) begin
						next_cur.target = msm_pkg::MSM_TGT_FIRST_ROM;
						next_state      = MSM_ROM;
					end else if (req.mapped && req.target != msm_pkg::MSM_TGT_RAM) begin
						next_state = MSM_ROM;
					end else begin
						next_cur.target = msm_pkg::MSM_TGT_RAM;
						next_state      = MSM_ROW;
						next_count      = is_dram
							? msm_pkg::CNT_W'(msm_pkg::RAS_CAS_CYC) : acc_cyc;
					end
				end
			end
			MSM_ROW: begin
				if (count <= 8'd1) begin
					next_state = is_dram ? MSM_COL : MSM_IDLE;
					next_count = acc_cyc;
					done       = !is_dram;
				end else begin
					next_count = count - 8'd1;
				end
			end
			MSM_COL, MSM_PAGE: begin
				if (count <= 8'd1) begin
					if (is_disp && beats != 4'd0) begin
						next_state = MSM_PAGE;
						next_beats = beats - 4'd1;
						next_count = acc_cyc;
					end else begin
						next_state = MSM_IDLE;
						done       = 1'b1;
					end
				end else begin
					next_count = count - 8'd1;
				end
			end
			MSM_REF_COL: begin
				if (count <= 8'd1) begin
					next_state = MSM_REF_ROW;
					next_count = acc_cyc;
				end else begin
					next_count = count - 8'd1;
				end
			end
			MSM_REF_ROW, MSM_ROM: begin
				if (count <= 8'd1) begin
					next_state = MSM_IDLE;
					done       = (state == MSM_ROM);
				end else begin
					next_count = count - 8'd1;
				end
			end
			default: begin
				next_state = MSM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state   <= MSM_IDLE;
			cur     <= '0;
			count   <= '0;
			beats   <= '0;
			is_disp <= 1'b0;
		end else begin
			state   <= next_state;
			cur     <= next_cur;
			count   <= next_count;
			beats   <= next_beats;
			is_disp <= next_is_disp;
		end
	end

	assign busy = (state != MSM_IDLE);

	// ----------------------------------------------------------------
	// Pin function decode (active high here, inverted at the flops)
	// ----------------------------------------------------------------
	logic [9:0] act, next_pins;
	logic       lo, hi, wr, col_ph, row_ph, ref_ph, ram_ph;
	localparam int BANKS = msm_pkg::BANK_COUNT;
	logic [BANKS-1:0] bank_hit;

	assign ram_ph = (state == MSM_ROW) || (state == MSM_COL) || (state == MSM_PAGE);
	assign row_ph = ram_ph;
	assign col_ph = (state == MSM_COL) || (state == MSM_PAGE) || (state == MSM_REF_COL)
		|| (state == MSM_REF_ROW);
	assign ref_ph = (state == MSM_REF_COL) || (state == MSM_REF_ROW);
	assign lo     = cur.low_byte;   // Even byte or word
	assign hi     = cur.high_byte;  // Odd byte or word
	assign wr     = cur.write && (state == MSM_COL || !is_dram);

	// One decoder per bank
	genvar gb;
	generate
		for (gb = 0; gb < BANKS; gb++) begin : g_bank
			assign bank_hit[gb] = (cur.bank == 3'(gb));
		end
	endgenerate

	// One type, one pin map; x8 and x16 types, x8 flash has one write strobe on pin 9
	always_comb begin
		act = '0;
		if (ram_ph || ref_ph) begin
			case (cfg.ram_type)
				msm_pkg::MSM_DRAM_X8: begin
					if (ref_ph) begin
						act[msm_pkg::DRAM_CAS_LAST:0] = '1;
						act[msm_pkg::PIN_P5] = (state == MSM_REF_ROW);
						act[msm_pkg::PIN_P6] = (state == MSM_REF_ROW);
					end else begin
						act[msm_pkg::DRAM_CAS_LAST:0] = col_ph ? bank_hit[4:0] : 5'h00;
						act[msm_pkg::PIN_P5] = lo;
						act[msm_pkg::PIN_P6] = hi;
						act[msm_pkg::PIN_P7] = col_ph && !cur.write;
						act[msm_pkg::PIN_P8] = col_ph && wr && lo;
						act[msm_pkg::PIN_P9] = col_ph && wr && hi;
					end
				end
				msm_pkg::MSM_DRAM_X16: begin
					if (ref_ph) begin
						act[msm_pkg::PIN_P6] = 1'b1;
						act[msm_pkg::PIN_P7] = 1'b1;
						act[msm_pkg::PIN_P5:0] = (state == MSM_REF_ROW) ? 6'h3F : 6'h00;
					end else begin
						act[msm_pkg::PIN_P5:0] = bank_hit;
						act[msm_pkg::PIN_P6] = col_ph && lo;
						act[msm_pkg::PIN_P7] = col_ph && hi;
						act[msm_pkg::PIN_P8] = col_ph && !cur.write;
						act[msm_pkg::PIN_P9] = col_ph && wr;
					end
				end
				msm_pkg::MSM_SRAM, msm_pkg::MSM_PSRAM_SMALL,
				msm_pkg::MSM_PSRAM_LARGE: begin
					if (ref_ph && cfg.ram_type == msm_pkg::MSM_PSRAM_SMALL) begin
						act[msm_pkg::PIN_P4] = 1'b1;
						act[msm_pkg::PIN_P5] = 1'b1;
					end else if (ref_ph) begin
						act[msm_pkg::PIN_P6] = 1'b1;
						act[msm_pkg::PIN_P7] = 1'b1;
					end else begin
						act[msm_pkg::PIN_P5:0] = bank_hit;
						act[msm_pkg::PIN_P6] = !cur.write && lo;
						act[msm_pkg::PIN_P7] = !cur.write && hi;
						act[msm_pkg::PIN_P8] = wr && lo;
						act[msm_pkg::PIN_P9] = wr && hi;
					end
				end
				msm_pkg::MSM_FLASH_X8, msm_pkg::MSM_FLASH_X16: begin
					if (!ref_ph) begin
						act[msm_pkg::PIN_P5:1] = bank_hit[5:1];
						if (cfg.ram_type == msm_pkg::MSM_FLASH_X8) begin
							act[msm_pkg::PIN_P9] = wr;
						end else begin
							act[msm_pkg::PIN_P8] = wr && lo;
							act[msm_pkg::PIN_P9] = wr && hi;
						end
					end
				end
				default: begin
					act = '0;
				end
			endcase
		end
		next_pins = ~act;
	end

	// ----------------------------------------------------------------
	// ROM selects, address and read strobe
	// ----------------------------------------------------------------
	logic next_boot_sel, next_second_sel, next_exp_rd, next_rom_x8;
	logic [7:0] next_upper;
	logic rom_ph;

	assign rom_ph = (state == MSM_ROM);

	always_comb begin
		next_boot_sel   = !(rom_ph && cur.target == msm_pkg::MSM_TGT_FIRST_ROM);
		next_second_sel = !(rom_ph && cur.mapped
			&& cur.target == msm_pkg::MSM_TGT_SECOND_ROM);
		next_upper      = cur.addr[msm_pkg::UPPER_MSB:msm_pkg::UPPER_LSB];
		if (rom_ph && !cur.mapped) begin
			next_upper = msm_pkg::UPPER_ZERO;
		end
		next_rom_x8 = (cur.target == msm_pkg::MSM_TGT_SECOND_ROM)
			? cfg.second_rom_x8 : boot_rom_x8;
		next_exp_rd = !(cfg.flash_oe_on_rd && exp_read);
	end

	// Pins 8/9 keep working in suspend; nothing gates them off
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_ctl_pins_n              <= msm_pkg::PINS_IDLE;
			boot_rom_select_n           <= 1'b1;
			second_rom_select_n         <= 1'b1;
			expansion_mem_read_strobe_n <= 1'b1;
			upper_addr                  <= '0;
			rom_x8                      <= 1'b0;
		end else begin
			mem_ctl_pins_n              <= next_pins;
			boot_rom_select_n           <= next_boot_sel;
			second_rom_select_n         <= next_second_sel;
			expansion_mem_read_strobe_n <= next_exp_rd;
			upper_addr                  <= next_upper;
			rom_x8                      <= next_rom_x8;
		end
	end

endmodule : msm_strobe_mapper
`default_nettype wire

// ===== test/msm_mem_model.sv
// Far-side memory model: watches the control pins and counts refresh pulses
`timescale 1ns/100ps
`default_nettype none
module msm_mem_model (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [9:0] pins_n,    // Shared control pins
	output logic      [7:0] ref_count  // Refresh pulses seen
);
	// ------------------------------------------------------------
	// Refresh pulse counter
	// ------------------------------------------------------------
	logic prev_even; // Last level of the even refresh pin
	// One organisation and one type fitted, flash above RAM
	// Bank 4 is never accessed, so a fall here is a refresh
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev_even <= 1'b1;
			ref_count <= 8'h00;
		end else begin
			prev_even <= pins_n[4];
			if (prev_even && !pins_n[4]) ref_count <= ref_count + 8'h01;
		end
	end
endmodule : msm_mem_model
`default_nettype wire

// ===== test/msm_strobe_mapper_asserts.sv
// Checker: port timing properties of the strobe mapper
`timescale 1ns/100ps
`default_nettype none
module msm_strobe_mapper_asserts (
	input wire logic              clock,
	input wire logic              resetn,
	input wire msm_pkg::msm_cfg_t cfg,
	input wire logic              req_valid,
	input wire msm_pkg::msm_req_t req,
	input wire logic              disp_valid,
	input wire logic [3:0]        disp_len,
	input wire logic              suspend,
	input wire logic              boot_rom_width_strap,
	input wire logic              exp_read,
	input wire logic              busy,
	input wire logic              done,
	input wire logic [9:0]        mem_ctl_pins_n,
	input wire logic              boot_rom_select_n,
	input wire logic              second_rom_select_n,
	input wire logic              expansion_mem_read_strobe_n,
	input wire logic [7:0]        upper_addr,
	input wire logic              rom_x8,
	input wire logic              boot_rom_x8
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	logic ram_cpu; // Plain CPU RAM cycle ending now
	assign ram_cpu = done && req_valid && !disp_valid && !req.mapped
		&& req.target == msm_pkg::MSM_TGT_RAM;
	property p_idle; !$past(busy) |-> mem_ctl_pins_n == msm_pkg::PINS_IDLE; endproperty
	a_idle: assert property (p_idle) else $error("pins active while idle");
	property p_rom2; !second_rom_select_n |-> $past(req.mapped)
		&& $past(req.target) == msm_pkg::MSM_TGT_SECOND_ROM; endproperty
	a_rom2: assert property (p_rom2) else $error("second rom select unmapped");
	property p_w2; !second_rom_select_n |-> rom_x8 == cfg.second_rom_x8; endproperty
	a_w2: assert property (p_w2) else $error("second rom width wrong");
	property p_boot; req_valid && !busy && !req.mapped && !cfg.boot_shadowed
		&& req.addr >= msm_pkg::BOOT_LO && req.addr <= msm_pkg::BOOT_HI
		|-> ##[1:12] (!boot_rom_select_n && upper_addr == 8'h00); endproperty
	a_boot: assert property (p_boot) else $error("boot window not selected");
	property p_strap; $rose(resetn) |-> ##4 boot_rom_x8 == boot_rom_width_strap; endproperty
	a_strap: assert property (p_strap) else $error("boot width not strap");
	property p_exp; expansion_mem_read_strobe_n
		== !$past(exp_read && cfg.flash_oe_on_rd); endproperty
	a_exp: assert property (p_exp) else $error("flash read strobe wrong");
	property p_dram; ram_cpu && cfg.ram_type == msm_pkg::MSM_DRAM_X8 |->
		mem_ctl_pins_n[6:5] == ~{req.high_byte, req.low_byte}
		&& !mem_ctl_pins_n[req.bank]; endproperty
	a_dram: assert property (p_dram) else $error("x8 dram strobes wrong");
	property p_x16; ram_cpu && cfg.ram_type == msm_pkg::MSM_DRAM_X16 |->
		mem_ctl_pins_n[7:6] == ~{req.high_byte, req.low_byte}
		&& !mem_ctl_pins_n[req.bank] && mem_ctl_pins_n[9] == !req.write; endproperty
	a_x16: assert property (p_x16) else $error("x16 dram strobes wrong");
	property p_sram; ram_cpu && cfg.ram_type inside {msm_pkg::MSM_SRAM,
		msm_pkg::MSM_PSRAM_SMALL, msm_pkg::MSM_PSRAM_LARGE} |-> !mem_ctl_pins_n[req.bank]
		&& (!req.write || mem_ctl_pins_n[9:8] == ~{req.high_byte, req.low_byte}); endproperty
	a_sram: assert property (p_sram) else $error("sram selects wrong");
endmodule : msm_strobe_mapper_asserts
bind msm_strobe_mapper msm_strobe_mapper_asserts u_chk (.clock, .resetn, .cfg, .req_valid,
	.req, .disp_valid, .disp_len, .suspend, .boot_rom_width_strap, .exp_read, .busy, .done,
	.mem_ctl_pins_n, .boot_rom_select_n, .second_rom_select_n,
	.expansion_mem_read_strobe_n, .upper_addr, .rom_x8, .boot_rom_x8);
`default_nettype wire

// ===== test/msm_strobe_mapper_tb.sv
// Testbench: access sequences on the strobe mapper with expected strobes
`timescale 1ns/100ps
`default_nettype none
module msm_strobe_mapper_tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              clock = 1'b0, resetn = 1'b0, req_valid = 1'b0, disp_valid = 1'b0;
	logic              suspend = 1'b0, boot_rom_width_strap = 1'b0, exp_read = 1'b0;
	logic [3:0]        disp_len = 4'h0;
	msm_pkg::msm_cfg_t cfg = '0;
	msm_pkg::msm_req_t req = '0, r;
	logic              busy, done, boot_rom_select_n, second_rom_select_n, rom_x8;
	logic              expansion_mem_read_strobe_n, boot_rom_x8, sb0, sb1;
	logic [9:0]        mem_ctl_pins_n, seen, m;
	logic [7:0]        upper_addr, ref_count, c0;
	int                fails = 0, checks_done = 0, n, b;
	// Low strobes per type: read low, write word, write high
	logic [9:0] mrd[7] = '{10'h0A0, 10'h140, 10'h040, 10'h040, 10'h040, 10'h000, 10'h000};
	logic [9:0] mwr[7] = '{10'h360, 10'h2C0, 10'h300, 10'h300, 10'h300, 10'h200, 10'h300};
	logic [9:0] mhi[7] = '{10'h240, 10'h280, 10'h200, 10'h200, 10'h200, 10'h200, 10'h200};
	int lat[7] = '{8, 8, 6, 8, 8, 6, 6};                      // Access cycles per type
	logic [23:0] ra[6] = '{24'h0F_0000, 24'h0F_FFFF, 24'h0E_FFFF, 24'h0F_8000,
		24'h12_3456, 24'h20_0000};
	int tg[6] = '{3, 3, 0, 0, 2, 1};                        // Target of each ROM case
	logic [1:0] es[6] = '{2'b10, 2'b10, 2'b11, 2'b11, 2'b01, 2'b10}; // Selects expected
	// Free-running clock
	always #5 clock = ~clock;
	msm_strobe_mapper dut (.clock, .resetn, .cfg, .req_valid, .req, .disp_valid, .disp_len,
		.suspend, .boot_rom_width_strap, .exp_read, .busy, .done, .mem_ctl_pins_n,
		.boot_rom_select_n, .second_rom_select_n, .expansion_mem_read_strobe_n,
		.upper_addr, .rom_x8, .boot_rom_x8);
	msm_mem_model u_mem (.clock, .resetn, .pins_n(mem_ctl_pins_n), .ref_count);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic tick(); @(posedge clock); #1; endtask : tick
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Reset with a given strap; selects must idle high meanwhile
	task automatic rst(input logic s);
		resetn = 1'b0;
		boot_rom_width_strap = s;
		repeat (5) tick();
		chk("pins in reset", 10'h3FF, mem_ctl_pins_n);
		chk("selects in reset", 10'h003, {8'h00, second_rom_select_n, boot_rom_select_n});
		resetn = 1'b1;
		repeat (6) tick();
		chk("boot width", {9'h000, s}, {9'h000, boot_rom_x8});
	endtask : rst
	// Hold one request until done, gathering every strobe that fell
	task automatic go(input logic d);
		tick();
		req = r;
		req_valid = !d;
		disp_valid = d;
		{seen, sb0, sb1, n} = {12'hFFF, 32'h0};
		do begin
			tick();
			n++;
			{seen, sb0, sb1} = {seen, sb0, sb1} & {mem_ctl_pins_n, boot_rom_select_n, second_rom_select_n};
		end while (done !== 1'b1 && n < 60);
		tick();
		{req_valid, disp_valid} = 2'b00;
	endtask : go
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		cfg.refresh_div = 8'h40;
		cfg.second_rom_x8 = 1'b1;
		rst(1'b0);
		for (int t = 0; t < 7; t++) begin
			cfg.ram_type = msm_pkg::msm_mem_type_t'(t);
			for (int k = 0; k < 3; k++) begin
				b = (k == 0) ? 1 : ((k == 1) ? 2 : 3);
				r = '{write: k != 0, low_byte: k != 2, high_byte: k != 0, bank: b[2:0],
					addr: 24'h00_1000, target: msm_pkg::MSM_TGT_RAM, mapped: 1'b0};
				go(1'b0);
				m = ((k == 0) ? mrd[t] : ((k == 1) ? mwr[t] : mhi[t])) | (10'h001 << b);
				chk("strobes low", m, ~seen & m);
				chk("cycles", 10'h001, {9'h000, n >= lat[t] && n <= lat[t] + 10});
				if (t == 5) chk("x8 flash low strobe", 10'h001, {9'h000, seen[8]});
			end
		end
		r.write = 1'b0;
		disp_len = 4'h3;
		cfg.ram_type = msm_pkg::MSM_DRAM_X8;
		go(1'b1);
		chk("burst cycles", 10'h001, {9'h000, n >= 26 && n <= 36});
		cfg.ram_type = msm_pkg::MSM_SRAM;
		go(1'b1);
		chk("burst refused", 10'h001, {9'h000, n == 60});
		for (int i = 0; i < 6; i++) begin
			cfg.boot_shadowed = (i == 3);
			r = '{write: 1'b0, low_byte: 1'b1, high_byte: 1'b1, bank: 3'h1, addr: ra[i],
				target: msm_pkg::msm_target_t'(tg[i]), mapped: tg[i] inside {1, 2}};
			go(1'b0);
			chk("rom selects", {8'h00, es[i]}, {8'h00, sb1, sb0});
		end
		cfg.ram_type = msm_pkg::MSM_PSRAM_SMALL;
		suspend = 1'b1;
		repeat (4) tick();
		c0 = ref_count;
		repeat (300) tick();
		chk("refresh in suspend", {2'b00, c0}, {2'b00, ref_count});
		r = '{1'b1, 1'b1, 1'b1, 3'h2, 24'h00_2000, msm_pkg::MSM_TGT_RAM, 1'b0};
		go(1'b0);
		chk("write strobes in suspend", 10'h300, ~seen & 10'h300);
		suspend = 1'b0;
		repeat (4) tick();
		c0 = ref_count;
		repeat (300) tick();
		chk("refresh running", 10'h001, {9'h000, ref_count != c0});
		cfg.flash_oe_on_rd = 1'b1;
		exp_read = 1'b1;
		repeat (2) tick();
		chk("flash read strobe", 10'h000, {9'h000, expansion_mem_read_strobe_n});
		exp_read = 1'b0;
		rst(1'b1);
		print_verdict();
	end
	// Watchdog well beyond the thousand or so cycles of the sequence
	initial begin
		#100_000;
		fails++;
		print_verdict();
	end
endmodule : msm_strobe_mapper_tb
`default_nettype wire
